// ===== mis_params.svh
// Constants of the multichannel I/O sampler: offsets, fields, counts
`ifndef MIS_PARAMS_SVH
`define MIS_PARAMS_SVH

// ------------------------------
// Sizes
// ------------------------------
`define MIS_CH        8
`define MIS_AW        8
`define MIS_EVW       26

// ------------------------------
// Timing, in ns, and rates in ms
// ------------------------------
`define MIS_CLK_NS    25
`define MIS_MS_NS     1000000
`define MIS_FILT_NS   2000
`define MIS_FRAME_END 3'h7
`define MIS_RATE_RST  10'h008
`define MIS_RATE_FAST 10'h001
`define MIS_RATE_SLOW 10'h3E8
`define MIS_BW_LIMIT  5'h08

// ------------------------------
// Readings
// ------------------------------
`define MIS_THR_RST   10'h00A
`define MIS_SCALE_MUL 11'h3E9
`define MIS_RAW_MAX   12'hFFF
`define MIS_CNT_MAX   10'h3FF
`define MIS_SCALED_MAX 10'h3E8

// ------------------------------
// Register byte offsets
// ------------------------------
`define MIS_A_CTRL    8'h00
`define MIS_A_DIN     8'h04
`define MIS_A_EVT     8'h08
`define MIS_A_SEL     8'h0C
`define MIS_A_THR     8'h10
`define MIS_A_RATE    8'h14
`define MIS_A_READ    8'h18
`define MIS_A_INFO    8'h1C

// ------------------------------
// Event register fields, reference select bit and info value
// ------------------------------
`define MIS_EV_SNS    0
`define MIS_EV_IN     8
`define MIS_EV_OUT    16
`define MIS_EV_IVERR  24
`define MIS_EV_BWERR  25
`define MIS_REF_BIT   8
`define MIS_INFO_VAL  32'h13E8_0888

`endif

// ===== mis_pkg.sv
// Types and helper functions of the multichannel I/O sampler
`include "mis_params.svh"

package mis_pkg;

   // Converter sample as delivered by the front end
   typedef struct packed {
      logic       valid;
      logic [2:0] chan;
      logic [9:0] data;
   } mis_adc_type;

   // Per analog channel state
   typedef struct packed {
      logic [9:0]  thr;
      logic [9:0]  rate;
      logic [9:0]  ivc;
      logic [19:0] acc;
      logic [9:0]  cnt;
      logic [11:0] raw;
      logic [9:0]  scaled;
      logic [9:0]  last;
   } mis_chan_type;

   // Whole block state
   typedef struct packed {
      mis_chan_type [`MIS_CH-1:0] ch;
      logic [`MIS_CH-1:0][7:0]    filt;
      logic [`MIS_CH-1:0]         din;
      logic [`MIS_CH-1:0]         dout_req;
      logic [`MIS_CH-1:0]         dout;
      logic                       ref_sel;
      logic [2:0]                 sel;
      logic [`MIS_EVW-1:0]        evt;
      logic [15:0]                ms_cnt;
      logic [2:0]                 frame_cnt;
      logic                       frame_strobe;
      logic                       pready;
      logic                       pslverr;
      logic [31:0]                prdata;
   } mis_state_type;

   // Bandwidth weight of one channel interval
   function automatic logic [4:0] mis_bw_w(input logic [9:0] r);
      if (r == `MIS_RATE_FAST) begin
         return 5'h02;
      end
      if (r == 10'h002) begin
         return 5'h01;
      end
      return 5'h00;
   endfunction

   // Legal interval: 1, 2, 4, or a multiple of 8 up to the slowest
   function automatic logic mis_rate_ok(input logic [9:0] r);
      if (r == 10'h001 || r == 10'h002 || r == 10'h004) begin
         return 1'b1;
      end
      return (r[2:0] == 3'h0) && (r != 10'h000) && (r <= `MIS_RATE_SLOW);
   endfunction

endpackage

// ===== mis_sampler.sv
// Multichannel I/O sampler: filtered inputs, outputs, averaged analog channels
// What this block does
// [R1] Eight digital inputs, each reached by its index.
// [R2] An input reads one while active, zero while idle.
// [R3] Each input is noise filtered before its level is shown.
// [R4] Eight outputs; writing one activates, reset leaves them inactive.
// [R5] Output readback shows the applied level, not the request.
// [R6] Eight analog channels; no sensor presence or type is reported.
// [R7] Scaled reading 0 to 1000 maps linearly onto 0 to 5 V.
// [R8] Full reading 0 to 4095, oversampled 10-bit conversions shown as 12 bits.
// [R9] Sensor event only when scaled reading moves more than the threshold.
// [R10] Threshold resets to 10.
// [R11] Threshold zero gives an event every interval.
// [R12] Interval in ms is the least spacing of sensor events.
// [R13] Intervals 1, 2, 4, 8 and multiples of 8 up to 1000 ms.
// [R14] Unsupported interval writes are refused and flag an error.
// [R15] Slow intervals still sample at full speed and report the average.
// [R16] Too much combined bandwidth is refused and flags an error.
// [R17] One reference select: set uses supply, clear uses precision reference.
// [R18] The reference select is not read back.
// [R19] Host should set the reference on open and wait before reading.
// [R20] Input level change raises an input event with index and level.
// [R21] Output level change raises an output event with index and level.
// [R22] Analog data goes out in 8 ms frames, bundling faster samples.
// [R23] Each channel keeps its last reported reading for comparison.
`timescale 1ns/1ps
`include "mis_params.svh"

module mis_sampler
   import mis_pkg::*;
#(
   parameter int MS_CYCLES   = `MIS_MS_NS / `MIS_CLK_NS,
   parameter int FILT_CYCLES = `MIS_FILT_NS / `MIS_CLK_NS
) (
   // Clock and reset
   input  wire logic               pclk,
   input  wire logic               presetn,
   // APB slave
   input  wire logic               psel,
   input  wire logic               penable,
   input  wire logic               pwrite,
   input  wire logic [`MIS_AW-1:0] paddr,
   input  wire logic [31:0]        pwdata,
   output logic      [31:0]        prdata,
   output logic                    pready,
   output logic                    pslverr,
   // Field side
   input  wire logic [`MIS_CH-1:0] digital_in_raw,
   input  wire mis_adc_type        adc_in,
   output logic      [`MIS_CH-1:0] digital_out_level,
   output logic                    ref_sel_supply,
   output logic                    frame_strobe
);

   // ------------------------------
   // State
   // ------------------------------
   mis_state_type       s;
   mis_state_type       n;
   logic [`MIS_CH-1:0]  end_v;
   logic                tick;
   logic                wr;
   logic                hit;
   logic [`MIS_EVW-1:0] set_v;
   logic [`MIS_EVW-1:0] clr_v;
   logic [4:0]          bw;
   logic [4:0]          bw_new;
   logic                smp;
   logic [21:0]         quo;
   logic [11:0]         raw;
   logic [22:0]         prod;
   logic [9:0]          sc;
   logic [9:0]          diff;
   mis_chan_type        c;

   // Outputs straight from flops
   assign prdata            = s.prdata;
   assign pready            = s.pready;
   assign pslverr           = s.pslverr;
   assign digital_out_level = s.dout;
   assign ref_sel_supply    = s.ref_sel;
   assign frame_strobe      = s.frame_strobe;

   // ------------------------------
   // Next state
   // ------------------------------
   always_comb begin
      n      = s;
      end_v  = '0;
      set_v  = '0;
      clr_v  = '0;
      bw     = '0;
      bw_new = '0;
      smp    = 1'b0;
      quo    = '0;
      raw    = '0;
      prod   = '0;
      sc     = '0;
      diff   = '0;
      c      = '0;
      n.pready       = 1'b0;
      n.pslverr      = 1'b0;
      n.frame_strobe = 1'b0;

      // Millisecond timebase and 8 ms frame strobe
      tick = (s.ms_cnt == 16'(MS_CYCLES - 1));
      n.ms_cnt = tick ? 16'h0000 : 16'(s.ms_cnt + 16'h0001);
      if (tick) begin
         n.frame_cnt = 3'(s.frame_cnt + 3'h1);
         n.frame_strobe = (s.frame_cnt == `MIS_FRAME_END); // R22
      end

      // Input filter: a level must differ for the whole window
      for (int i = 0; i < `MIS_CH; i++) begin
         if (digital_in_raw[i] == s.din[i]) begin
            n.filt[i] = 8'h00; // R3
         end else if (s.filt[i] == 8'(FILT_CYCLES - 1)) begin
            n.filt[i] = 8'h00;
            n.din[i] = digital_in_raw[i]; // R2
            set_v[`MIS_EV_IN + i] = 1'b1; // R20
         end else begin
            n.filt[i] = 8'(s.filt[i] + 8'h01); // R3
         end
      end

      // Outputs apply the request one cycle later; changes raise events
      n.dout = s.dout_req; // R4
      for (int i = 0; i < `MIS_CH; i++) begin
         if (s.dout[i] != s.dout_req[i]) begin
            set_v[`MIS_EV_OUT + i] = 1'b1; // R21
         end
      end

      // Analog channels: full-speed accumulate, average at interval end
      for (int i = 0; i < `MIS_CH; i++) begin
         c   = s.ch[i];
         bw  = 5'(bw + mis_bw_w(c.rate));
         smp = adc_in.valid && (adc_in.chan == 3'(i));
         end_v[i] = tick && (10'(c.ivc + 10'h001) >= c.rate); // R12
         if (end_v[i]) begin
            n.ch[i].ivc = 10'h000;
            if (c.cnt != 10'h000) begin
               // Average scaled by four: 10-bit samples shown as 12 bits
               quo  = {c.acc, 2'b00} / {12'h000, c.cnt}; // R15 R8
               raw  = (quo[21:12] != 10'h000) ? `MIS_RAW_MAX : quo[11:0];
               prod = 23'(raw) * 23'(`MIS_SCALE_MUL); // R7
               sc   = prod[21:12];
               diff = (sc > c.last) ? 10'(sc - c.last) : 10'(c.last - sc);
               n.ch[i].raw    = raw;
               n.ch[i].scaled = sc;
               if (c.thr == 10'h000 || diff > c.thr) begin // R9 R11
                  n.ch[i].last = sc; // R23
                  set_v[`MIS_EV_SNS + i] = 1'b1;
               end
            end
            // A sample landing on the boundary opens the next window
            n.ch[i].acc = smp ? {10'h000, adc_in.data} : 20'h00000;
            n.ch[i].cnt = smp ? 10'h001 : 10'h000;
         end else begin
            if (tick) begin
               n.ch[i].ivc = 10'(c.ivc + 10'h001);
            end
            if (smp && c.cnt != `MIS_CNT_MAX) begin
               n.ch[i].acc = 20'(c.acc + {10'h000, adc_in.data}); // R15
               n.ch[i].cnt = 10'(c.cnt + 10'h001);
            end
         end
      end

      // APB decode; one wait state, answer registered
      hit = (paddr == `MIS_A_CTRL) || (paddr == `MIS_A_DIN)
         || (paddr == `MIS_A_EVT) || (paddr == `MIS_A_SEL)
         || (paddr == `MIS_A_THR) || (paddr == `MIS_A_RATE)
         || (paddr == `MIS_A_READ) || (paddr == `MIS_A_INFO);
      wr = psel && penable && pwrite && s.pready;
      if (psel && penable && !s.pready) begin
         n.pready  = 1'b1;
         n.pslverr = !hit;
         n.prdata  = 32'h0000_0000;
         if (!pwrite) begin
            unique case (paddr)
               `MIS_A_CTRL: begin
                  n.prdata[7:0] = s.dout; // R5 R18
               end
               `MIS_A_DIN: begin
                  n.prdata[7:0] = s.din; // R1
               end
               `MIS_A_EVT: begin
                  n.prdata[`MIS_EVW-1:0] = s.evt;
               end
               `MIS_A_SEL: begin
                  n.prdata[2:0] = s.sel;
               end
               `MIS_A_THR: begin
                  n.prdata[9:0] = s.ch[s.sel].thr;
               end
               `MIS_A_RATE: begin
                  n.prdata[9:0] = s.ch[s.sel].rate;
               end
               `MIS_A_READ: begin
                  n.prdata[9:0]   = s.ch[s.sel].scaled;
                  n.prdata[27:16] = s.ch[s.sel].raw;
               end
               `MIS_A_INFO: begin
                  n.prdata = `MIS_INFO_VAL; // R6
               end
               default: begin
                  n.prdata = 32'h0000_0000;
               end
            endcase
         end
      end

      // Register writes take effect at the completing edge
      bw_new = 5'(bw - mis_bw_w(s.ch[s.sel].rate) + mis_bw_w(pwdata[9:0]));
      if (wr) begin
         unique case (paddr)
            `MIS_A_CTRL: begin
               n.dout_req = pwdata[7:0]; // R4
               n.ref_sel  = pwdata[`MIS_REF_BIT]; // R17
            end
            `MIS_A_EVT: begin
               clr_v = pwdata[`MIS_EVW-1:0];
            end
            `MIS_A_SEL: begin
               n.sel = pwdata[2:0];
            end
            `MIS_A_THR: begin
               n.ch[s.sel].thr = pwdata[9:0];
            end
            `MIS_A_RATE: begin
               if (!mis_rate_ok(pwdata[9:0])) begin
                  set_v[`MIS_EV_IVERR] = 1'b1; // R13 R14
               end else if (bw_new > `MIS_BW_LIMIT) begin
                  set_v[`MIS_EV_BWERR] = 1'b1; // R16
               end else begin
                  n.ch[s.sel].rate = pwdata[9:0]; // R13
                  n.ch[s.sel].ivc  = 10'h000;
               end
            end
            default: begin
               n.sel = s.sel;
            end
         endcase
      end

      // Sticky events: a new event wins over a clear in the same cycle
      n.evt = (s.evt & ~clr_v) | set_v;
   end

   // ------------------------------
   // Register
   // ------------------------------
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         s <= '0;
         for (int i = 0; i < `MIS_CH; i++) begin
            s.ch[i].thr  <= `MIS_THR_RST; // R10
            s.ch[i].rate <= `MIS_RATE_RST; // R22
         end
      end else begin
         s <= n;
      end
   end

   // ------------------------------
   // Assertions
   // ------------------------------
   default clocking cb @(posedge pclk);
   endclocking
   default disable iff (!presetn);

   sequence wr_ctrl;
      psel && penable && pwrite && pready && paddr == `MIS_A_CTRL;
   endsequence

   sequence wr_rate3;
      psel && penable && pwrite && pready && paddr == `MIS_A_RATE
         && pwdata[9:0] == 10'h003;
   endsequence

   // Any completed interval write
   sequence wr_rate;
      psel && penable && pwrite && pready && paddr == `MIS_A_RATE;
   endsequence

   AST_IN_FILT: assert property ( // R3
      $changed(s.din[0]) |-> $past(digital_in_raw[0]) == s.din[0]
         && $past(s.filt[0]) == 8'(FILT_CYCLES - 1))
      else $error("input level changed without full filter window");

   AST_IN_EVT: assert property ( // R20
      $changed(s.din[0]) |-> s.evt[`MIS_EV_IN])
      else $error("input change raised no event");

   AST_OUT_LAG: assert property ( // R5
      wr_ctrl |=> s.dout == $past(s.dout) ##1 s.dout == $past(pwdata[7:0], 2))
      else $error("output did not follow request one cycle later");

   AST_OUT_EVT: assert property ( // R21
      $changed(s.dout[0]) |-> s.evt[`MIS_EV_OUT])
      else $error("output change raised no event");

   AST_REF: assert property ( // R17
      wr_ctrl |=> ref_sel_supply == $past(pwdata[`MIS_REF_BIT]))
      else $error("reference select not applied");

   AST_BAD_RATE: assert property ( // R14
      wr_rate3 |=> s.evt[`MIS_EV_IVERR] && $stable(s.ch[s.sel].rate))
      else $error("unsupported interval accepted");

   AST_ZERO_THR: assert property ( // R11
      end_v[2] && s.ch[2].thr == 10'h000 && s.ch[2].cnt != 10'h000
         |=> s.evt[`MIS_EV_SNS + 2] && s.ch[2].last == s.ch[2].scaled)
      else $error("zero threshold gave no event");

   AST_FRAME: assert property ( // R22
      frame_strobe |=> !frame_strobe [*8])
      else $error("frame strobes too close");

   AST_PREADY: assert property (
      pready |=> !pready)
      else $error("ready held longer than one cycle");

   AST_SLVERR: assert property (
      pslverr |-> pready)
      else $error("error response without ready");

   AST_RATE_ERR: assert property ( // R14
      wr_rate ##0 !mis_rate_ok(pwdata[9:0]) |=> s.evt[`MIS_EV_IVERR])
      else $error("illegal interval write raised no error");

   AST_BW: assert property ( // R16
      bw <= `MIS_BW_LIMIT)
      else $error("combined interval weight above the limit");

   // Per-channel guards: events, stored intervals and readings
   for (genvar g = 0; g < `MIS_CH; g++) begin : g_chan_chk
      AST_SNS_EDGE: assert property ( // R12
         set_v[`MIS_EV_SNS + g] |-> end_v[g])
         else $error("sensor event raised away from an interval end");

      AST_RATE_LEGAL: assert property ( // R13
         $changed(s.ch[g].rate) |-> mis_rate_ok(s.ch[g].rate))
         else $error("unsupported interval stored");

      AST_LAST_EVT: assert property ( // R23
         $changed(s.ch[g].last) |-> s.evt[`MIS_EV_SNS + g])
         else $error("reported reading moved without an event");

      AST_SCALED_MAX: assert property ( // R7
         s.ch[g].scaled <= `MIS_SCALED_MAX)
         else $error("scaled reading above full scale");

      AST_IN_EVT_CH: assert property ( // R20
         $changed(s.din[g]) |-> s.evt[`MIS_EV_IN + g])
         else $error("input change on a channel raised no event");

      AST_OUT_EVT_CH: assert property ( // R21
         $changed(s.dout[g]) |-> s.evt[`MIS_EV_OUT + g])
         else $error("output change on a channel raised no event");
   end

endmodule

// ===== mis_adc_model.sv
// Converter front-end model that streams samples into the sampler
`timescale 1ns/1ps

module mis_adc_model
   import mis_pkg::*;
(
   // Clock and reset
   input  wire logic       pclk,
   input  wire logic       presetn,
   // Bench control
   input  wire logic       en,
   input  wire logic [2:0] chan,
   input  wire logic [9:0] lo,
   input  wire logic [9:0] hi,
   // Sample stream
   output mis_adc_type     adc_out
);
   logic [1:0] phase;
   logic       pick;

   // One sample every four cycles, low and high values in turn
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         phase <= 2'h0;
         pick <= 1'b0;
         adc_out <= '0;
      end else begin
         phase <= phase + 2'h1;
         if (en && phase == 2'h3) begin
            adc_out.valid <= 1'b1;
            adc_out.chan <= chan;
            adc_out.data <= pick ? hi : lo;
            pick <= ~pick;
         end else begin
            adc_out.valid <= 1'b0;
            adc_out.data <= ~adc_out.data; // Never hold a stale sample
         end
      end
   end
endmodule

// ===== mis_sampler_tb.sv
// Self-checking bench of the multichannel I/O sampler
`timescale 1ns/1ps
`include "mis_params.svh"

module mis_sampler_tb
   import mis_pkg::*;
;
   localparam int MSC = 20;
   localparam int FLT = 4;
   logic               pclk;
   logic               presetn;
   logic               psel;
   logic               penable;
   logic               pwrite;
   logic [`MIS_AW-1:0] paddr;
   logic [31:0]        pwdata;
   logic [31:0]        prdata;
   logic               pready;
   logic               pslverr;
   logic [`MIS_CH-1:0] din_raw;
   mis_adc_type        adc;
   logic [`MIS_CH-1:0] dout;
   logic               ref_sup;
   logic               fstb;
   logic [9:0]         adc_lo;
   logic [9:0]         adc_hi;
   int                 err_total;
   int                 num_checks;
   logic [31:0]        rd;
   logic               er;

   mis_sampler #(.MS_CYCLES(MSC), .FILT_CYCLES(FLT)) i_mis_sampler (
      .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .digital_in_raw(din_raw),
      .adc_in(adc), .digital_out_level(dout), .ref_sel_supply(ref_sup),
      .frame_strobe(fstb));

   mis_adc_model i_mis_adc_model (
      .pclk(pclk), .presetn(presetn), .en(1'b1), .chan(3'h2),
      .lo(adc_lo), .hi(adc_hi), .adc_out(adc));

   // Clock
   initial begin
      pclk = 1'b0;
      forever #12.5 pclk = ~pclk;
   end

   // ------------------------------
   // Helpers
   // ------------------------------
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      num_checks++;
      if (got !== exp) begin
         err_total++;
         $display("mismatch at %0t: got %h expected %h", $time, got, exp);
      end
   endtask

   task automatic end_sim();
      $display("checks %0d mismatches %0d", num_checks, err_total);
      if (err_total == 0 && num_checks > 0) begin
         $display("Run complete: PASS");
      end else begin
         $display("Run complete: FAIL");
      end
      $finish;
   endtask

   // One APB transfer, held until pready is sampled high
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      int n;
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      n = 0;
      do begin
         @(posedge pclk);
         n++;
      end while (pready !== 1'b1 && n < 50);
      if (pready !== 1'b1) begin
         err_total++;
         end_sim();
      end
      rd = prdata;
      er = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask

   // ------------------------------
   // Scenarios
   // ------------------------------
   task automatic t_reset();
      apb(1'b1, `MIS_A_SEL, 32'h0);
      apb(1'b0, `MIS_A_THR, 32'h0);
      chk(rd, 32'h0000_000A);
      apb(1'b0, `MIS_A_RATE, 32'h0);
      chk(rd, 32'h0000_0008);
      apb(1'b0, `MIS_A_CTRL, 32'h0);
      chk(rd, 32'h0);
      chk({24'h0, dout}, 32'h0);
      apb(1'b0, `MIS_A_INFO, 32'h0);
      chk(rd, `MIS_INFO_VAL);
      apb(1'b0, 8'h40, 32'h0);
      chk({er, rd[30:0]}, 32'h8000_0000);
   endtask

   task automatic t_outputs();
      apb(1'b1, `MIS_A_CTRL, 32'h0000_01A5);
      repeat (2) @(posedge pclk);
      chk({23'h0, ref_sup, dout}, 32'h0000_01A5);
      apb(1'b0, `MIS_A_CTRL, 32'h0);
      chk(rd, 32'h0000_00A5);
      apb(1'b1, `MIS_A_EVT, 32'h03FF_FFFF);
      apb(1'b1, `MIS_A_CTRL, 32'h0000_0021);
      repeat (2) @(posedge pclk);
      chk({23'h0, ref_sup, dout}, 32'h0000_0021);
      apb(1'b0, `MIS_A_EVT, 32'h0);
      chk(rd & 32'h00FF_0000, 32'h0084_0000);
   endtask

   task automatic t_inputs();
      din_raw <= 8'h81;
      repeat (FLT - 2) @(posedge pclk);
      din_raw <= 8'h00;
      repeat (FLT + 4) @(posedge pclk);
      apb(1'b0, `MIS_A_DIN, 32'h0);
      chk(rd, 32'h0);
      din_raw <= 8'h3C;
      repeat (FLT + 4) @(posedge pclk);
      apb(1'b0, `MIS_A_DIN, 32'h0);
      chk(rd, 32'h0000_003C);
      apb(1'b0, `MIS_A_EVT, 32'h0);
      chk(rd & 32'h0000_FF00, 32'h0000_3C00);
   endtask

   task automatic t_intervals();
      logic [31:0] ok [6] = '{32'h1, 32'h2, 32'h4, 32'h8, 32'h10, 32'h3E8};
      logic [31:0] bad [5] = '{32'h0, 32'h3, 32'h9, 32'h11, 32'h3F0};
      apb(1'b1, `MIS_A_SEL, 32'h1);
      foreach (ok[i]) begin
         apb(1'b1, `MIS_A_RATE, ok[i]);
         apb(1'b0, `MIS_A_RATE, 32'h0);
         chk(rd, ok[i]);
      end
      foreach (bad[i]) begin
         apb(1'b1, `MIS_A_EVT, 32'h03FF_FFFF);
         apb(1'b1, `MIS_A_RATE, bad[i]);
         apb(1'b0, `MIS_A_RATE, 32'h0);
         chk(rd, 32'h0000_03E8);
         apb(1'b0, `MIS_A_EVT, 32'h0);
         chk(rd & 32'h0100_0000, 32'h0100_0000);
      end
   endtask

   task automatic t_bandwidth();
      apb(1'b1, `MIS_A_EVT, 32'h03FF_FFFF);
      for (int c = 0; c < 5; c++) begin
         apb(1'b1, `MIS_A_SEL, 32'(c));
         apb(1'b1, `MIS_A_RATE, 32'h1);
         apb(1'b0, `MIS_A_RATE, 32'h0);
         chk(rd, (c < 4) ? 32'h1 : 32'h8);
         apb(1'b0, `MIS_A_EVT, 32'h0);
         chk(rd & 32'h0200_0000, (c < 4) ? 32'h0 : 32'h0200_0000);
      end
      for (int c = 0; c < 4; c++) begin
         apb(1'b1, `MIS_A_SEL, 32'(c));
         apb(1'b1, `MIS_A_RATE, 32'h8);
      end
   endtask

   // Hold a sample pattern on channel 2 and judge events and readings
   task automatic a_step(input logic [9:0] lo, input logic [9:0] hi, input logic [31:0] thr,
                         input logic [31:0] ev2, input logic [31:0] rdv);
      adc_lo <= lo;
      adc_hi <= hi;
      apb(1'b1, `MIS_A_THR, thr);
      repeat (25 * MSC) @(posedge pclk);
      apb(1'b0, `MIS_A_EVT, 32'h0);
      chk(rd & 32'h4, 32'h4);
      apb(1'b1, `MIS_A_EVT, 32'h0000_0004);
      repeat (9 * MSC) @(posedge pclk);
      apb(1'b0, `MIS_A_EVT, 32'h0);
      chk(rd & 32'h4, ev2);
      apb(1'b0, `MIS_A_READ, 32'h0);
      chk(rd, rdv);
   endtask

   task automatic t_analog();
      apb(1'b1, `MIS_A_SEL, 32'h2);
      a_step(10'h3FF, 10'h3FF, 32'hA, 32'h0, 32'h0FFC_03E8);
      a_step(10'h064, 10'h12C, 32'hA, 32'h0, 32'h0320_00C3);
      a_step(10'h064, 10'h12C, 32'h0, 32'h4, 32'h0320_00C3);
   endtask

   task automatic strobe_gap(output int n);
      n = 0;
      do begin
         @(posedge pclk);
         n++;
      end while (fstb !== 1'b1 && n < 1000);
      if (fstb !== 1'b1) begin
         err_total++;
         end_sim();
      end
   endtask

   task automatic t_frame();
      int n;
      strobe_gap(n);
      strobe_gap(n);
      chk(32'(n), 32'(8 * MSC));
   endtask

   // Main sequence
   initial begin
      err_total = 0;
      num_checks = 0;
      presetn = 1'b0;
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = '0;
      pwdata = '0;
      din_raw = '0;
      adc_lo = '0;
      adc_hi = '0;
      repeat (20) @(posedge pclk);
      presetn <= 1'b1;
      t_reset();
      t_outputs();
      t_inputs();
      t_intervals();
      t_bandwidth();
      t_analog();
      t_frame();
      end_sim();
   end
endmodule
